// ===== src/pdc_pkg.sv
// Purpose: Shared constants and types for the PCI DMA channel control block
// Assumes: 32-bit AXI4-Lite register bus, one clock
// Notes:   Offsets are byte addresses of aligned words
package pdc_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] PDC_OFS_CTRL     = 8'h00;
   localparam logic [7:0] PDC_OFS_COUNT    = 8'h04;
   localparam logic [7:0] PDC_OFS_CHAIN_LO = 8'h08;
   localparam logic [7:0] PDC_OFS_CHAIN_HI = 8'h0c;
   localparam logic [7:0] PDC_OFS_IRQ_STS  = 8'h10;
   localparam logic [7:0] PDC_OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] PDC_OFS_DESC     = 8'h18;

   // ----------------------------------------------------------------
   // Control field positions
   // ----------------------------------------------------------------
   localparam int PDC_B_CHANNEL_RESET_BIT  = 0;
   localparam int PDC_B_DIR    = 1;
   localparam int PDC_B_SIZE   = 2;
   localparam int PDC_B_SWAP   = 4;
   localparam int PDC_B_ACT    = 6;
   localparam int PDC_B_CHAIN  = 7;
   localparam int PDC_B_DONEIE = 8;
   localparam int PDC_B_CHNIE  = 9;

   // Interrupt status bits
   localparam int PDC_I_DATA  = 0;
   localparam int PDC_I_CHAIN = 1;
   localparam int PDC_I_DONE  = 2;

   // ----------------------------------------------------------------
   // Reset values and encodings
   // ----------------------------------------------------------------
   localparam logic       PDC_RST_CHANNEL_RESET_BIT = 1'b1;
   localparam logic [1:0] PDC_SZ_DWORD  = 2'h0;
   localparam logic [1:0] PDC_SZ_QWORD  = 2'h1;
   localparam logic [1:0] PDC_SZ_BURST  = 2'h2;
   localparam logic [23:0] PDC_BYTES_DWORD = 24'h000004;
   localparam logic [23:0] PDC_BYTES_QWORD = 24'h000008;
   localparam logic [23:0] PDC_BYTES_BURST = 24'h000020;

   // Stop delay after active bit is cleared mid-transfer (ns)
   localparam int PDC_STOP_NS     = 20;
   localparam int PDC_CLK_NS      = 5;
   localparam int PDC_STOP_CYC    = (PDC_STOP_NS + PDC_CLK_NS - 1) / PDC_CLK_NS;

   localparam logic [1:0] PDC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] PDC_RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      PDC_IDLE  = 4'b0001,
      PDC_MOVE  = 4'b0010,
      PDC_FETCH = 4'b0100,
      PDC_STOP  = 4'b1000
   } pdc_state_e;

endpackage

// ===== src/pdc_swap.sv
// Purpose: Registered optional byte reversal within a 32-bit word
// Assumes: Data valid with in_valid
// Notes:   One cycle latency
module pdc_swap (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        swap_en,
   input  wire logic        in_valid,
   input  wire logic [31:0] in_data,
   output logic             out_valid,
   output logic [31:0]      out_data
);
   logic [31:0] data_nxt;
   logic [31:0] data_r;
   logic        vld_r;

   always_comb begin
      data_nxt = in_data;
      if (swap_en) begin
         data_nxt = {in_data[7:0], in_data[15:8], in_data[23:16], in_data[31:24]};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_r <= 32'h0;
         vld_r  <= 1'b0;
      end else begin
         data_r <= in_valid ? data_nxt : data_r;
         vld_r  <= in_valid;
      end
   end

   assign out_valid = vld_r;
   assign out_data  = data_r;
endmodule

// ===== src/pdc_channel.sv
// Purpose: Control logic of one PCI DMA channel with AXI4-Lite registers
// Assumes: Single clock; data mover outside; beat_ack per beat from mover
// Notes:   Channel reset bit holds the sequencer, active and chain-follow flags and the swap stage in reset while set
//
// What this block does
// - Done interrupt enable gates a completion interrupt; resets to zero.
// - Chain-follow flag is read-only, set by nonzero chain address load.
// - Chain-follow flag clears on channel reset or zero chain address load.
// - Upper-word chain address stores skip the zero test entirely.
// - On completion, fetch next descriptor only when chain-follow is set.
// - Writing active starts; stays clear if count zero and chain clear.
// - Nonzero chain address write sets active and starts transfer.
// - Clearing active mid-transfer stops after a short delay.
// - Active clears itself on normal finish or on error.
// - Byte-swap bit reverses bytes in each 32-bit word; resets zero.
// - Beat size: 00 dword, 01 qword, 10 four-qword burst, 11 reserved.
// - Direction 1 moves internal to PCI, 0 PCI to internal; resets zero.
// - Channel reset resets to one and holds channel logic in reset.
// - Zero count moves nothing; count decrements by bytes per beat.
// - Done status sets from chain-complete or data-complete with enable.
module pdc_channel
   import pdc_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        beat_ack,
   input  wire logic        xfer_error,
   input  wire logic        desc_done,
   input  wire logic [31:0] desc_chain_addr,
   input  wire logic        mover_valid,
   input  wire logic [31:0] mover_data,
   output logic             beat_req,
   output logic [1:0]       beat_size_sel,
   output logic             direction_sel,
   output logic             desc_fetch,
   output logic [63:0]      chain_addr,
   output logic             swap_valid,
   output logic [31:0]      swap_data,
   output logic             irq
);
   import pdc_pkg::*;

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic        channel_reset_bit_r, channel_reset_bit_nxt, dir_r, dir_nxt, swap_r, swap_nxt;
   logic        act_r, act_nxt, chain_r, chain_nxt, doneie_r, doneie_nxt;
   logic        chnie_r, chnie_nxt;
   logic [1:0]  size_r, size_nxt;
   logic [23:0] cnt_r, cnt_nxt, beat_bytes;
   logic [63:0] caddr_r, caddr_nxt;
   logic [2:0]  ists_r, ists_nxt, imask_r, imask_nxt;
   logic        irq_r, irq_nxt, req_r, req_nxt, fetch_r, fetch_nxt;
   logic [2:0]  stop_r, stop_nxt;
   pdc_state_e  st_r, st_nxt;
   logic        aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt, r_r, r_nxt;
   logic [7:0]  awa_r, awa_nxt;
   logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
   logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
   logic        wr_go, ch_rst, data_evt, chain_evt;
   logic [31:0] ctrl_rd;

   always_comb begin
      case (size_r)
         PDC_SZ_DWORD: beat_bytes = PDC_BYTES_DWORD;
         PDC_SZ_QWORD: beat_bytes = PDC_BYTES_QWORD;
         PDC_SZ_BURST: beat_bytes = PDC_BYTES_BURST;
         default:      beat_bytes = PDC_BYTES_DWORD;
      endcase
   end

   assign ctrl_rd = {22'h0, chnie_r, doneie_r, chain_r, act_r, 1'b0, swap_r,
                     size_r, dir_r, channel_reset_bit_r};
   assign ch_rst  = channel_reset_bit_r;

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   assign wr_go = aw_r && w_r && !b_r;

   always_comb begin
      aw_nxt  = aw_r;
      w_nxt   = w_r;
      b_nxt   = b_r;
      r_nxt   = r_r;
      awa_nxt = awa_r;
      wd_nxt  = wd_r;
      rd_nxt  = rd_r;
      br_nxt  = br_r;
      rr_nxt  = rr_r;
      if (s_axi_awvalid && !aw_r) begin
         aw_nxt  = 1'b1;
         awa_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_r) begin
         w_nxt  = 1'b1;
         wd_nxt = s_axi_wdata;
      end
      if (wr_go) begin
         aw_nxt = 1'b0;
         w_nxt  = 1'b0;
         b_nxt  = 1'b1;
         br_nxt = (awa_r > PDC_OFS_DESC || awa_r[1:0] != 2'h0) ? PDC_RESP_SLVERR
                                                               : PDC_RESP_OKAY;
      end
      if (b_r && s_axi_bready) begin
         b_nxt = 1'b0;
      end
      if (s_axi_arvalid && !r_r) begin
         r_nxt  = 1'b1;
         rr_nxt = PDC_RESP_OKAY;
         case (s_axi_araddr)
            PDC_OFS_CTRL:     rd_nxt = ctrl_rd;
            PDC_OFS_COUNT:    rd_nxt = {8'h0, cnt_r};
            PDC_OFS_CHAIN_LO: rd_nxt = caddr_r[31:0];
            PDC_OFS_CHAIN_HI: rd_nxt = caddr_r[63:32];
            PDC_OFS_IRQ_STS:  rd_nxt = {29'h0, ists_r};
            PDC_OFS_IRQ_MASK: rd_nxt = {29'h0, imask_r};
            PDC_OFS_DESC:     rd_nxt = {28'h0, st_r};
            default: begin
               rd_nxt = 32'h0;
               rr_nxt = PDC_RESP_SLVERR;
            end
         endcase
      end else if (r_r && s_axi_rready) begin
         r_nxt = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Channel control and sequencing
   // ----------------------------------------------------------------
   always_comb begin
      channel_reset_bit_nxt  = channel_reset_bit_r;
      dir_nxt    = dir_r;
      swap_nxt   = swap_r;
      size_nxt   = size_r;
      doneie_nxt = doneie_r;
      chnie_nxt  = chnie_r;
      act_nxt    = act_r;
      chain_nxt  = chain_r;
      cnt_nxt    = cnt_r;
      caddr_nxt  = caddr_r;
      imask_nxt  = imask_r;
      st_nxt     = st_r;
      req_nxt    = 1'b0;
      fetch_nxt  = 1'b0;
      stop_nxt   = stop_r;
      data_evt   = 1'b0;
      chain_evt  = 1'b0;
      // Hardware-side sequencing first; a register write below overrides fields
      case (st_r)
         PDC_IDLE: begin
            if (act_r) begin
               st_nxt = PDC_MOVE;
            end
         end
         PDC_MOVE: begin
            req_nxt = (cnt_r != 24'h0) && !beat_ack;
            if (xfer_error) begin
               act_nxt = 1'b0;
               st_nxt  = PDC_IDLE;
            end else if (!act_r) begin
               stop_nxt = 3'(PDC_STOP_CYC);
               st_nxt   = PDC_STOP;
            end else if (beat_ack && cnt_r > beat_bytes) begin
               cnt_nxt = cnt_r - beat_bytes;
            end else if (beat_ack || cnt_r == 24'h0) begin
               cnt_nxt  = 24'h0;
               data_evt = 1'b1;
               if (chain_r) begin
                  fetch_nxt = 1'b1;
                  st_nxt    = PDC_FETCH;
               end else begin
                  act_nxt   = 1'b0;
                  chain_evt = 1'b1;
                  st_nxt    = PDC_IDLE;
               end
            end
         end
         PDC_FETCH: begin
            if (xfer_error) begin
               act_nxt = 1'b0;
               st_nxt  = PDC_IDLE;
            end else if (desc_done) begin
               caddr_nxt = {32'h0, desc_chain_addr};
               chain_nxt = desc_chain_addr != 32'h0;
               st_nxt    = PDC_MOVE;
            end
         end
         PDC_STOP: begin
            if (stop_r <= 3'h1) begin
               st_nxt = PDC_IDLE;
            end else begin
               stop_nxt = stop_r - 3'h1;
            end
         end
         default: st_nxt = PDC_IDLE;
      endcase
      if (wr_go) begin
         case (awa_r)
            PDC_OFS_CTRL: begin
               channel_reset_bit_nxt  = wd_r[PDC_B_CHANNEL_RESET_BIT];
               dir_nxt    = wd_r[PDC_B_DIR];
               size_nxt   = wd_r[PDC_B_SIZE +: 2];
               swap_nxt   = wd_r[PDC_B_SWAP];
               doneie_nxt = wd_r[PDC_B_DONEIE];
               chnie_nxt  = wd_r[PDC_B_CHNIE];
               if (wd_r[PDC_B_ACT]) begin
                  act_nxt = act_r || (cnt_r != 24'h0) || chain_r;
               end else begin
                  act_nxt = 1'b0;
               end
            end
            PDC_OFS_COUNT: cnt_nxt = {wd_r[23:2], 2'h0};
            PDC_OFS_CHAIN_LO: begin
               caddr_nxt[31:0] = wd_r;
               chain_nxt = wd_r != 32'h0;
               if (wd_r != 32'h0) begin
                  act_nxt = 1'b1;
               end
            end
            PDC_OFS_CHAIN_HI: caddr_nxt[63:32] = wd_r;
            PDC_OFS_IRQ_MASK: imask_nxt = wd_r[2:0];
            default: ;
         endcase
      end
      if (ch_rst && !(wr_go && awa_r == PDC_OFS_CTRL)) begin
         act_nxt   = 1'b0;
         chain_nxt = 1'b0;
         st_nxt    = PDC_IDLE;
         req_nxt   = 1'b0;
         fetch_nxt = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status: set wins over write-one-to-clear
   // ----------------------------------------------------------------
   always_comb begin
      ists_nxt = ists_r;
      if (wr_go && awa_r == PDC_OFS_IRQ_STS) begin
         ists_nxt = ists_r & ~wd_r[2:0];
      end
      if (data_evt) begin
         ists_nxt[PDC_I_DATA] = 1'b1;
      end
      if (chain_evt) begin
         ists_nxt[PDC_I_CHAIN] = 1'b1;
      end
      if ((data_evt && doneie_r) || (chain_evt && chnie_r)) begin
         ists_nxt[PDC_I_DONE] = 1'b1;
      end
      irq_nxt = |(ists_nxt & imask_r);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         channel_reset_bit_r <= PDC_RST_CHANNEL_RESET_BIT;
         dir_r   <= 1'b0;
         swap_r  <= 1'b0;
         size_r  <= PDC_SZ_DWORD;
         doneie_r <= 1'b0;
         chnie_r <= 1'b0;
         act_r   <= 1'b0;
         chain_r <= 1'b0;
         cnt_r   <= 24'h0;
         caddr_r <= 64'h0;
         ists_r  <= 3'h0;
         imask_r <= 3'h0;
         irq_r   <= 1'b0;
         req_r   <= 1'b0;
         fetch_r <= 1'b0;
         stop_r  <= 3'h0;
         st_r    <= PDC_IDLE;
         aw_r    <= 1'b0;
         w_r     <= 1'b0;
         b_r     <= 1'b0;
         r_r     <= 1'b0;
         awa_r   <= 8'h0;
         wd_r    <= 32'h0;
         rd_r    <= 32'h0;
         br_r    <= 2'h0;
         rr_r    <= 2'h0;
      end else begin
         channel_reset_bit_r <= channel_reset_bit_nxt;
         dir_r   <= dir_nxt;
         swap_r  <= swap_nxt;
         size_r  <= size_nxt;
         doneie_r <= doneie_nxt;
         chnie_r <= chnie_nxt;
         act_r   <= act_nxt;
         chain_r <= chain_nxt;
         cnt_r   <= cnt_nxt;
         caddr_r <= caddr_nxt;
         ists_r  <= ists_nxt;
         imask_r <= imask_nxt;
         irq_r   <= irq_nxt;
         req_r   <= req_nxt;
         fetch_r <= fetch_nxt;
         stop_r  <= stop_nxt;
         st_r    <= st_nxt;
         aw_r    <= aw_nxt;
         w_r     <= w_nxt;
         b_r     <= b_nxt;
         r_r     <= r_nxt;
         awa_r   <= awa_nxt;
         wd_r    <= wd_nxt;
         rd_r    <= rd_nxt;
         br_r    <= br_nxt;
         rr_r    <= rr_nxt;
      end
   end

   pdc_swap u_swap (
      .aclk      (aclk),
      .aresetn   (aresetn && !ch_rst),
      .swap_en   (swap_r),
      .in_valid  (mover_valid),
      .in_data   (mover_data),
      .out_valid (swap_valid),
      .out_data  (swap_data)
   );

   assign s_axi_awready = s_axi_awvalid && !aw_r;
   assign s_axi_wready  = s_axi_wvalid && !w_r;
   assign s_axi_bvalid  = b_r;
   assign s_axi_bresp   = br_r;
   assign s_axi_arready = s_axi_arvalid && !r_r;
   assign s_axi_rvalid  = r_r;
   assign s_axi_rdata   = rd_r;
   assign s_axi_rresp   = rr_r;
   assign beat_req      = req_r;
   assign beat_size_sel = size_r;
   assign direction_sel = dir_r;
   assign desc_fetch    = fetch_r;
   assign chain_addr    = caddr_r;
   assign irq           = irq_r;
endmodule

// ===== tb/pdc_channel_chk.sv
// Purpose: Port-level checks of the DMA channel control block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every pdc_channel instance
module pdc_channel_chk
   import pdc_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        mover_valid,
   input wire logic [31:0] mover_data,
   input wire logic        swap_valid,
   input wire logic [31:0] swap_data,
   input wire logic        beat_req,
   input wire logic        desc_fetch,
   input wire logic [1:0]  beat_size_sel,
   input wire logic        irq
);
   logic [31:0] mv_rev;
   assign mv_rev = {mover_data[7:0], mover_data[15:8], mover_data[23:16], mover_data[31:24]};
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----
   // Register bus
   // ----
   sequence s_w_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_b_ans;
      s_w_taken |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_b_ans: assert property (p_b_ans) else $error("write answer late");
   property p_rd_ans;
      s_ar_taken |=> s_axi_rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
   property p_r_stand;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_stand: assert property (p_r_stand) else $error("read data dropped");
   property p_r_zero;
      s_axi_rvalid && s_axi_rresp == PDC_RESP_SLVERR |-> s_axi_rdata == 32'h0;
   endproperty
   a_r_zero: assert property (p_r_zero) else $error("error read not zero");
   // ----
   // Channel outputs
   // ----
   property p_rst_quiet;
      disable iff (1'b0)
      !aresetn |=> !beat_req && !desc_fetch && !irq && beat_size_sel == 2'h0;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not reset");
   property p_fetch_pulse;
      desc_fetch |=> !desc_fetch;
   endproperty
   a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch not a pulse");
   property p_swap_lat;
      swap_valid |-> $past(mover_valid);
   endproperty
   a_swap_lat: assert property (p_swap_lat) else $error("swap valid unexpected");
   property p_swap_val;
      swap_valid |-> swap_data == $past(mover_data) || swap_data == $past(mv_rev);
   endproperty
   a_swap_val: assert property (p_swap_val) else $error("swap data wrong");
   // Status is sticky, so the line may only drop after a register write
   property p_irq_fall;
      $fell(irq) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) ||
                     $past(s_axi_wvalid, 3) || $past(s_axi_wvalid, 4);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
endmodule

bind pdc_channel pdc_channel_chk pdc_channel_chk_i (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata, .s_axi_rresp, .mover_valid, .mover_data, .swap_valid, .swap_data,
   .beat_req, .desc_fetch, .beat_size_sel, .irq
);

// ===== tb/pdc_mover_model.sv
// Purpose: Behavioural data mover and descriptor source
// Assumes: Channel request outputs are registered
// Notes:   Every descriptor ends the chain with a zero address
module pdc_mover_model (
   input  wire logic   aclk,
   input  wire logic   aresetn,
   input  wire logic   beat_req,
   input  wire logic   desc_fetch,
   input  wire logic   slow,
   input  wire logic   err_cmd,
   output logic        beat_ack,
   output logic        desc_done,
   output logic [31:0] desc_chain_addr,
   output logic        xfer_error,
   output int          n_beats,
   output int          n_fetch
);
   timeunit 1ns;
   timeprecision 1ps;
   int gap = 0;
   int fw = 0;
   initial begin
      {beat_ack, desc_done, xfer_error} = 3'h0;
      desc_chain_addr = 32'h5a5a_5a5a;
      n_beats = 0;
      n_fetch = 0;
      forever begin
         @(posedge aclk);
         beat_ack <= 1'b0;
         xfer_error <= err_cmd && beat_req;
         if (gap > 0) gap--;
         else if (beat_req && aresetn) begin
            // Gap of two or more lets the registered request settle
            beat_ack <= 1'b1;
            n_beats++;
            gap = slow ? 30 : 2 + n_beats % 3;
         end
         if (fw == 1) begin
            desc_done <= 1'b1;
            desc_chain_addr <= 32'h0;
         end else begin
            desc_done <= 1'b0;
            desc_chain_addr <= ~desc_chain_addr;
         end
         if (desc_fetch) n_fetch++;
         fw = desc_fetch ? 3 : (fw > 0 ? fw - 1 : 0);
      end
   end
endmodule

// ===== tb/tb_pdc_channel.sv
// Purpose: Self-checking bench for the DMA channel control block
// Assumes: Mover model answers beats and descriptor fetches
// Notes:   Expectations come from integer figures kept in the bench
module tb_pdc_channel;
   timeunit 1ns;
   timeprecision 1ps;
   import pdc_pkg::*;
   logic        aclk, aresetn;
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, mover_data = 32'h0, seed = 32'h0001_0f79;
   logic [31:0] s_axi_rdata, swap_data, desc_chain_addr, d, e;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp, beat_size_sel, r;
   logic [63:0] chain_addr;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, s_axi_bready = 1'b1, mover_valid = 1'b0;
   logic        slow = 1'b0, err_cmd = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        beat_ack, xfer_error, desc_done, beat_req, direction_sel;
   logic        desc_fetch, swap_valid, irq, irq_a;
   int          n_mismatch = 0, n_tests = 0, n_beats, n_fetch, b0, f0, n;
   int          sz_bytes[3] = '{4, 8, 32};
   pdc_channel pdc_channel_i (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .beat_ack, .xfer_error, .desc_done,
      .desc_chain_addr, .mover_valid, .mover_data, .beat_req, .beat_size_sel,
      .direction_sel, .desc_fetch, .chain_addr, .swap_valid, .swap_data, .irq
   );
   pdc_mover_model pdc_mover_model_i (
      .aclk, .aresetn, .beat_req, .desc_fetch, .slow, .err_cmd, .beat_ack, .desc_done,
      .desc_chain_addr, .xfer_error, .n_beats, .n_fetch
   );
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // ----
   // Helpers
   // ----
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic finish_test();
      $display("Compares %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] g, input logic [63:0] x);
      n_tests++;
      if (g !== x) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic hang();
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h wait expired", $time, 1'b0, 1'b1);
      finish_test();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int k;
      k = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && k < 60);
      if (k >= 60) hang();
   endtask
   // Ready is held back a cycle so the answer has to stand
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int k;
      logic ok;
      k = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         ok = s_axi_rvalid && s_axi_rready;
         v = s_axi_rdata;
         rs = s_axi_rresp;
         if (k == 2) s_axi_rready <= 1'b1;
      end while (!ok && k < 60);
      s_axi_rready <= 1'b0;
      if (k >= 60) hang();
   endtask
   task automatic wait_idle();
      int k;
      k = 0;
      do begin
         rd(PDC_OFS_CTRL, d, r);
         k++;
      end while (d[PDC_B_ACT] !== 1'b0 && k < 400);
      if (k >= 400) hang();
   endtask
   // ----
   // Sequence
   // ----
   initial begin
      aresetn = 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      chk(64'(irq), 64'h0);
      rd(PDC_OFS_CTRL, d, r);
      chk({30'h0, r, d}, {30'h0, PDC_RESP_OKAY, 32'h1});
      rd(8'h1c, d, r);
      chk({30'h0, r, d}, {30'h0, PDC_RESP_SLVERR, 32'h0});
      for (int s = 0; s < 3; s++) begin
         for (int dr = 0; dr < 2; dr++) begin
            e = 32'(s << PDC_B_SIZE | dr << PDC_B_DIR);
            wr(PDC_OFS_CTRL, e);
            rd(PDC_OFS_CTRL, d, r);
            chk(64'(d), 64'(e));
            chk(64'({beat_size_sel, direction_sel}), 64'({s[1:0], dr[0]}));
         end
      end
      for (int sw = 0; sw < 2; sw++) begin
         wr(PDC_OFS_CTRL, 32'(sw << PDC_B_SWAP));
         e = rnd();
         mover_valid <= 1'b1;
         mover_data <= e;
         @(posedge aclk);
         mover_valid <= 1'b0;
         mover_data <= rnd();
         @(posedge aclk);
         if (sw == 1) e = {e[7:0], e[15:8], e[23:16], e[31:24]};
         chk({31'h0, swap_valid, swap_data}, {31'h0, 1'b1, e});
      end
      $display("Fields and swap done");
      wr(PDC_OFS_COUNT, 32'h0);
      wr(PDC_OFS_CTRL, 32'h0c0);
      rd(PDC_OFS_CTRL, d, r);
      chk(64'(d[7:6]), 64'h0);
      rd(PDC_OFS_IRQ_STS, d, r);
      chk(64'(d), 64'h0);
      for (int s = 0; s < 3; s++) begin
         b0 = n_beats;
         f0 = n_fetch;
         wr(PDC_OFS_COUNT, 32'((3 + s) * sz_bytes[s]));
         wr(PDC_OFS_CTRL, 32'(s << PDC_B_SIZE | 1 << PDC_B_ACT | (s % 2) << PDC_B_DONEIE));
         wait_idle();
         chk(64'(n_beats - b0), 64'(3 + s));
         chk(64'(n_fetch - f0), 64'h0);
         rd(PDC_OFS_COUNT, d, r);
         chk(64'(d), 64'h0);
         rd(PDC_OFS_IRQ_STS, d, r);
         chk(64'(d[2:0]), 64'((s % 2) << 2 | 3));
         wr(PDC_OFS_IRQ_MASK, 32'h7);
         rd(PDC_OFS_IRQ_MASK, d, r);
         chk(64'(d), 64'h7);
         irq_a = irq;
         wr(PDC_OFS_IRQ_MASK, 32'h0);
         rd(PDC_OFS_IRQ_MASK, d, r);
         chk(64'(irq_a ^ irq), 64'h1);
         wr(PDC_OFS_IRQ_STS, 32'h7);
         rd(PDC_OFS_IRQ_STS, d, r);
         chk(64'({irq, d}), 64'h0);
      end
      $display("Plain transfers done");
      wr(PDC_OFS_CTRL, 32'h0);
      wr(PDC_OFS_COUNT, 32'h8);
      wr(PDC_OFS_CHAIN_HI, 32'h1);
      rd(PDC_OFS_CTRL, d, r);
      chk(64'(d[7:6]), 64'h0);
      slow <= 1'b1;
      f0 = n_fetch;
      wr(PDC_OFS_CHAIN_LO, 32'h100);
      rd(PDC_OFS_CTRL, d, r);
      chk(64'(d[7:6]), 64'h3);
      chk(chain_addr, 64'h0000_0001_0000_0100);
      slow <= 1'b0;
      wait_idle();
      chk(64'(n_fetch - f0), 64'h1);
      rd(PDC_OFS_CTRL, d, r);
      chk(64'(d[7:6]), 64'h0);
      $display("Chained transfer done");
      wr(PDC_OFS_COUNT, 32'h40);
      slow <= 1'b1;
      wr(PDC_OFS_CTRL, 32'h040);
      wr(PDC_OFS_CTRL, 32'h000);
      n = 0;
      while (beat_req && n < 10) begin
         @(posedge aclk);
         n++;
      end
      chk(64'(beat_req), 64'h0);
      rd(PDC_OFS_CTRL, d, r);
      chk(64'(d[6]), 64'h0);
      wr(PDC_OFS_COUNT, 32'h40);
      wr(PDC_OFS_CHAIN_LO, 32'h200);
      n = 0;
      while (!beat_req && n < 10) begin
         @(posedge aclk);
         n++;
      end
      err_cmd <= 1'b1;
      @(posedge aclk);
      err_cmd <= 1'b0;
      wait_idle();
      wr(PDC_OFS_CTRL, 32'h1);
      rd(PDC_OFS_CTRL, d, r);
      chk(64'(d), 64'h1);
      slow <= 1'b0;
      $display("Stop, error and channel reset done");
      finish_test();
   end
endmodule
